// file: bench/compact_timer_properties.sv
// Port-level assertions for the compact timer
`timescale 1ns/1ps
module compact_timer_properties (
	// Clock, reset and inputs
	input wire        i_clk,
	input wire        i_rstn,
	input wire        i_ce,
	input wire        i_cnt_tick,
	input wire        i_hsel,
	input wire [1:0]  i_htrans,
	input wire        i_hwrite,
	input wire        i_hready,
	// Outputs
	input wire [31:0] o_hrdata,
	input wire        o_hreadyout,
	input wire        o_hresp,
	input wire        o_pin,
	input wire        o_pin_oe,
	input wire        o_flag_a,
	input wire        o_flag_p
);
	logic rd_q;
	// Read data may only move after a read was taken
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			rd_q <= 1'b0;
		else
			rd_q <= i_hsel & i_hready & i_htrans == 2'b10 & !i_hwrite & i_ce;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_resp_okay: assert property (!o_hresp) else $error("bad hresp");
	a_ready_high: assert property (o_hreadyout) else $error("wait state");
	a_rdata_held: assert property (!rd_q |-> $stable(o_hrdata)) else $error("rdata moved");
	a_flag_a_tick: assert property ($rose(o_flag_a) |-> $past(i_cnt_tick)) else $error("flag a");
	a_flag_p_tick: assert property ($rose(o_flag_p) |-> $past(i_cnt_tick)) else $error("flag p");
	a_pin_frozen: assert property (!i_ce |=> $stable(o_pin)) else $error("pin moved");
	a_oe_frozen: assert property (!i_ce |=> $stable(o_pin_oe)) else $error("oe moved");
	a_flags_frozen: assert property (!i_ce |=> $stable({o_flag_a, o_flag_p})) else $error("flags");
endmodule

bind compact_timer compact_timer_properties u_props (.i_clk, .i_rstn, .i_ce, .i_cnt_tick, .i_hsel,
	.i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .o_pin, .o_pin_oe,
	.o_flag_a, .o_flag_p);

// file: bench/compact_timer_test.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ps
module compact_timer_test;
	logic        i_clk = 0, i_rstn = 0, i_ce = 0, i_cnt_tick = 0, i_hsel = 0, i_hwrite = 0;
	logic [7:0]  i_haddr = 0;
	logic [1:0]  i_htrans = 0;
	logic [31:0] i_hwdata = 0, rd;
	wire  [31:0] o_hrdata;
	wire         o_hreadyout, o_hresp, o_pin, o_pin_oe, o_flag_a, o_flag_p, lvl;
	integer      seed = 88003;
	int          fails = 0, checks_done = 0, a, i, k, c, s, o, p, pr, du;
	compact_timer u_dut (.i_clk, .i_rstn, .i_ce, .i_cnt_tick, .i_hsel, .i_haddr, .i_htrans,
		.i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout,
		.o_hresp, .o_pin, .o_pin_oe, .o_flag_a, .o_flag_p);
	pin_load u_load (.i_pin(o_pin), .i_oe(o_pin_oe), .o_level(lvl));
	initial forever #25 i_clk = ~i_clk;
	initial begin
		#2000000;
		fails++;
		tally_and_finish();
	end
	task chk(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		i_hsel <= 1; i_haddr <= ad; i_htrans <= 2'h2; i_hwrite <= w;
		do @(posedge i_clk); while (!o_hreadyout);
		i_htrans <= 0; i_hwdata <= d;
		do @(posedge i_clk); while (!o_hreadyout);
		rd = o_hrdata;
	endtask
	task rdr(input int ad, e); bus(0, ad, 0); chk(rd, e); endtask
	// Ticks are single cycles so counts are exact
	task tk(input int n);
		repeat (n) begin i_cnt_tick <= 1; @(posedge i_clk); end
		i_cnt_tick <= 0;
		repeat (2) @(posedge i_clk);
	endtask
	// Changes made with the counter off, then a clean enable edge
	task cfg(input logic [7:0] v);
		bus(1, 0, 0); bus(1, 4, v); bus(1, 28, 3); bus(1, 0, 8);
		repeat (2) @(posedge i_clk);
	endtask
	function logic cmp_pin(int code, int init);
		return code == 0 ? init[0] : code == 3 ? !init[0] : code == 2;
	endfunction
	function logic pwm_pin(int cnt, int duty, int act, int inv);
		return (cnt < duty ? act[0] : !act[0]) ^ inv[0];
	endfunction
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1;
		i_ce <= 1;
		for (a = 8; a <= 32; a += 4) rdr(a, 0);
		a = $random(seed) & 16'hffff;
		bus(1, 16, a); bus(1, 20, a >> 8); bus(1, 8, 255);
		rdr(16, a & 255);
		rdr(20, a >> 8);
		rdr(8, 0);
		bus(1, 16, 5); bus(1, 20, 0);
		for (c = 0; c < 4; c++) begin
			k = $random(seed) & 1;
			cfg(8'(1 + c * 16 + k * 8));
			chk(o_pin, k);
			tk(5);
			chk({o_pin_oe, o_flag_a, o_flag_p, o_pin}, {3'b110, cmp_pin(c, k)});
			rdr(8, 0);
		end
		i_ce <= 0;
		tk(3);
		i_ce <= 1;
		rdr(8, 0);
		cfg(8'hc1);
		tk(5);
		chk({o_pin_oe, lvl, o_flag_a}, 3'b001);
		bus(1, 16, 3); bus(1, 24, 1);
		cfg(8'h00);
		tk(3);
		chk({o_flag_a, o_flag_p}, 2'b10);
		rdr(8, 3);
		tk(253);
		chk(o_flag_p, 1);
		rdr(12, 0);
		for (i = 0; i < 3; i++) begin
			a = i == 0 ? $random(seed) & 255 | 1 : 256 * i;
			s = i / 2; o = $random(seed) & 1; p = $random(seed) & 1;
			pr = s ? a : 256; du = s ? 256 : a; c = 0;
			bus(1, 16, a); bus(1, 20, a >> 8);
			cfg(8'(8'ha1 + o * 8 + p * 4 + s * 2));
			repeat (3) begin
				k = $random(seed) & 255; tk(k); c = (c + k) % pr;
				chk(o_pin, pwm_pin(c, du, o, p));
			end
		end
		cfg(8'(8'h81 + o * 8 + p * 4));
		tk(7);
		rdr(8, 7);
		chk(o_pin, pwm_pin(1, 0, o, p));
		cfg(8'(8'h91 + o * 8 + p * 4));
		chk(o_pin, pwm_pin(0, 1, o, p));
		// Zero compare A with clear on A: counter runs past the period byte
		bus(1, 16, 0); bus(1, 20, 0);
		cfg(8'h01);
		tk(300);
		chk({o_flag_a, o_flag_p}, 2'b00);
		rdr(8, 44);
		rdr(12, 1);
		bus(1, 0, 0);
		tk(3);
		rdr(8, 44);
		tally_and_finish();
	end
endmodule

// file: bench/pin_load.sv
// Load on the timer pin with a weak pull-down
`timescale 1ns/1ps
module pin_load (
	// Pin driver
	input  wire i_pin,
	input  wire i_oe,
	// Level seen by the load
	output wire o_level
);
	// Released pin falls to the pull-down, never a stale level
	assign o_level = i_oe ? i_pin : 1'b0;
endmodule

// file: hw/compact_timer.v
// Compact 16-bit timer with compare A, period P, PWM and AHB-Lite registers
`timescale 1ns/1ps
`include "compact_timer_defs.vh"

module compact_timer (
	// Clock, reset, enable
	input  wire        i_clk,
	input  wire        i_rstn,
	input  wire        i_ce,
	// Counter clock tick from the source selector
	input  wire        i_cnt_tick,
	// AHB-Lite slave
	input  wire        i_hsel,
	input  wire [7:0]  i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire [31:0] i_hwdata,
	input  wire        i_hready,
	output reg  [31:0] o_hrdata,
	output reg         o_hreadyout,
	output reg         o_hresp,
	// Timer pin and events
	output reg         o_pin,
	output reg         o_pin_oe,
	output reg         o_flag_a,
	output reg         o_flag_p
);

	// Software-visible registers
	reg  [7:0]  ctrl0_r;
	reg  [7:0]  ctrl1_r;
	reg  [7:0]  cmpa_lo_r;
	reg  [7:0]  cmpa_hi_r;
	reg  [7:0]  period_r;

	// Timer state
	reg  [15:0] count_r;
	reg  [15:0] count_nxt;
	reg         en_d_r;
	reg         out_r;
	reg         out_nxt;
	reg         set_a;
	reg         set_p;
	reg         do_clear;

	// Bus write tracking and read mux
	reg         wr_pend_r;
	reg  [7:0]  wr_addr_r;
	reg  [31:0] rd_data;

	// Control fields
	wire        enable    = ctrl0_r[`CT_C0_ENABLE];
	wire [1:0]  mode      = {ctrl1_r[`CT_C1_MODE_HI], ctrl1_r[`CT_C1_MODE_LO]};
	wire [1:0]  pin_fn    = {ctrl1_r[`CT_C1_PIN_HI], ctrl1_r[`CT_C1_PIN_LO]};
	wire        out_ctrl  = ctrl1_r[`CT_C1_OUT_CTRL];
	wire        polarity  = ctrl1_r[`CT_C1_POLARITY];
	wire        swap      = ctrl1_r[`CT_C1_SWAP];
	wire        clr_sel   = ctrl1_r[`CT_C1_CLR_SEL];
	wire [15:0] cmpa      = {cmpa_hi_r, cmpa_lo_r};
	wire        is_cmp    = (mode == `CT_MODE_CMP);
	wire        is_pwm    = (mode == `CT_MODE_PWM);

	// A rising enable zeroes the counter, so that tick is dropped
	wire        en_rise   = enable & ~en_d_r;
	wire        running   = enable & i_cnt_tick & ~en_rise;

	// Zero detects: zero compare A never matches, zero period means 65536
	wire        a_zero    = (cmpa == 16'h0000);
	wire        p_zero    = (period_r == 8'h00);

	// Compare on the value the counter takes this tick
	wire [15:0] count_inc = count_r + 16'h0001;
	wire        match_a   = running & (count_inc == cmpa) & ~a_zero;
	// A zero period byte matches only on the wrap to zero
	wire        match_p   = running & (count_inc[15:8] == period_r)
				& (count_inc[7:0] == 8'h00);
	wire        overflow  = running & (count_r == 16'hffff);

	// Duty and period thresholds, seventeen bits to hold 65536
	wire [16:0] p_span    = p_zero ? 17'h10000 : {1'b0, period_r, 8'h00};
	wire [16:0] a_span    = a_zero ? 17'h10000 : {1'b0, cmpa};
	wire [16:0] duty_val  = swap ? p_span : {1'b0, cmpa};
	wire [16:0] per_val   = swap ? a_span : p_span;
	wire        pwm_act   = (duty_val >= per_val) |
				({1'b0, count_r} < duty_val);

	// Output-control bit is the active level of the waveform
	wire        pwm_lvl   = pwm_act ? out_ctrl : ~out_ctrl;

	// AHB address phase
	wire        ahb_req   = i_hsel & i_hready & (i_htrans == `CT_HTRANS_NONSEQ);
	wire        rd_take   = ahb_req & ~i_hwrite;
	wire        wr_take   = ahb_req & i_hwrite;

	// Data-phase write strobes, one per writable register
	wire        wr_c0     = wr_pend_r & (wr_addr_r == `CT_ADDR_CTRL0);
	wire        wr_c1     = wr_pend_r & (wr_addr_r == `CT_ADDR_CTRL1);
	wire        wr_alo    = wr_pend_r & (wr_addr_r == `CT_ADDR_CMPA_LO);
	wire        wr_ahi    = wr_pend_r & (wr_addr_r == `CT_ADDR_CMPA_HI);
	wire        wr_per    = wr_pend_r & (wr_addr_r == `CT_ADDR_PERIOD);
	wire        wr_flg    = wr_pend_r & (wr_addr_r == `CT_ADDR_FLAGS);

	// Write one to clear each flag
	wire        clr_a     = wr_flg & i_hwdata[`CT_FLAG_A];
	wire        clr_p     = wr_flg & i_hwdata[`CT_FLAG_P];

	// Clear and flag decisions per mode
	always @* begin
		do_clear = 1'b0;
		set_a    = 1'b0;
		set_p    = 1'b0;
		case (mode)
		`CT_MODE_PWM: begin
			// Period comparator clears, the other only sets its flag
			set_a = match_a;
			set_p = match_p;
			if (swap)
				do_clear = match_a;
			else
				do_clear = match_p;
		end
		default: begin
			// Compare, timer and the undefined mode count alike
			if (clr_sel) begin
				set_a    = match_a;
				do_clear = match_a;
			end else begin
				set_a    = match_a;
				set_p    = match_p;
				do_clear = match_p | (p_zero & overflow);
			end
		end
		endcase
	end

	// Counter next value; overflow wraps to zero naturally
	// A falling enable leaves the count where it stopped
	always @* begin
		count_nxt = count_r;
		if (en_rise)
			count_nxt = `CT_RST_COUNT;
		else if (running) begin
			if (do_clear)
				count_nxt = `CT_RST_COUNT;
			else
				count_nxt = count_inc;
		end
	end

	// Output level, before polarity
	always @* begin
		out_nxt = out_r;
		if (en_rise) begin
			out_nxt = out_ctrl;
		end else begin
			case (mode)
			`CT_MODE_CMP: begin
				// Only comparator A moves the pin
				if (set_a) begin
					case (pin_fn)
					`CT_PIN_LOW:    out_nxt = 1'b0;
					`CT_PIN_HIGH:   out_nxt = 1'b1;
					`CT_PIN_TOGGLE: out_nxt = ~out_r;
					default:        out_nxt = out_r;
					endcase
				end
			end
			`CT_MODE_PWM: begin
				// Waveform keeps running under a forced level
				case (pin_fn)
				`CT_PIN_NONE: out_nxt = ~out_ctrl;
				`CT_PIN_LOW:  out_nxt = out_ctrl;
				`CT_PIN_HIGH: out_nxt = pwm_lvl;
				default:      out_nxt = out_r;
				endcase
			end
			default: out_nxt = out_r;
			endcase
		end
	end

	// Read mux
	always @* begin
		rd_data = 32'h00000000;
		case (i_haddr)
		`CT_ADDR_CTRL0:   rd_data = {24'h000000, ctrl0_r};
		`CT_ADDR_CTRL1:   rd_data = {24'h000000, ctrl1_r};
		// Read-only count bytes
		`CT_ADDR_CNT_LO:  rd_data = {24'h000000, count_r[7:0]};
		`CT_ADDR_CNT_HI:  rd_data = {24'h000000, count_r[15:8]};
		// Compare A bytes, no pairing latch
		`CT_ADDR_CMPA_LO: rd_data = {24'h000000, cmpa_lo_r};
		`CT_ADDR_CMPA_HI: rd_data = {24'h000000, cmpa_hi_r};
		`CT_ADDR_PERIOD:  rd_data = {24'h000000, period_r};
		// Sticky flags in bits 1:0
		`CT_ADDR_FLAGS:   rd_data = {30'h00000000, o_flag_p, o_flag_a};
		default:          rd_data = 32'h00000000;
		endcase
	end

	// Write tracking: write data follows its address by one cycle
	localparam PH_IDLE  = 1'b0;
	localparam PH_WDATA = 1'b1;

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_pend_r <= PH_IDLE;
		end else if (i_ce) begin
			case (wr_pend_r)
			PH_IDLE:  wr_pend_r <= wr_take ? PH_WDATA : PH_IDLE;
			PH_WDATA: wr_pend_r <= wr_take ? PH_WDATA : PH_IDLE;
			default:  wr_pend_r <= PH_IDLE;
			endcase
		end
	end

	// Address held for the data phase of a write
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			wr_addr_r <= 8'h00;
		else if (i_ce & wr_take)
			wr_addr_r <= i_haddr;
	end

	// No wait states
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_hreadyout <= 1'b1;
		else if (i_ce)
			o_hreadyout <= 1'b1;
	end

	// No error responses
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_hresp <= 1'b0;
		else if (i_ce)
			o_hresp <= 1'b0;
	end

	// Read data taken at the address edge, stands through the data phase
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_hrdata <= 32'h00000000;
		else if (i_ce & rd_take)
			o_hrdata <= rd_data;
	end

	// Only the enable bit acts; bits 2:0 are unimplemented and read 0
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			ctrl0_r <= `CT_RST_BYTE;
		else if (i_ce & wr_c0)
			ctrl0_r <= {i_hwdata[7:3], 3'b000};
	end

	// Mode and pin settings; change them only with the counter off
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			ctrl1_r <= `CT_RST_BYTE;
		else if (i_ce & wr_c1)
			ctrl1_r <= i_hwdata[7:0];
	end

	// Compare A bytes, each written alone
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			cmpa_lo_r <= `CT_RST_BYTE;
		else if (i_ce & wr_alo)
			cmpa_lo_r <= i_hwdata[7:0];
	end

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			cmpa_hi_r <= `CT_RST_BYTE;
		else if (i_ce & wr_ahi)
			cmpa_hi_r <= i_hwdata[7:0];
	end

	// Period byte
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			period_r <= `CT_RST_BYTE;
		else if (i_ce & wr_per)
			period_r <= i_hwdata[7:0];
	end

	// Enable edge detector; resets low like the enable itself
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			en_d_r <= 1'b0;
		else if (i_ce)
			en_d_r <= enable;
	end

	// Counter, frozen with the clock enable low
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			count_r <= `CT_RST_COUNT;
		else if (i_ce)
			count_r <= count_nxt;
	end

	// Pin level before polarity
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			out_r <= 1'b0;
		else if (i_ce)
			out_r <= out_nxt;
	end

	// Polarity applied last, so forced levels invert too
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_pin <= 1'b0;
		else if (i_ce)
			o_pin <= out_nxt ^ polarity;
	end

	// Pin released in timer mode and in the undefined mode
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_pin_oe <= 1'b0;
		else if (i_ce)
			o_pin_oe <= is_cmp | is_pwm;
	end

	// Set wins over a simultaneous write-one clear
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_flag_a <= 1'b0;
		else if (i_ce) begin
			if (set_a)
				o_flag_a <= 1'b1;
			else if (clr_a)
				o_flag_a <= 1'b0;
		end
	end

	// Same priority for the period flag
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_flag_p <= 1'b0;
		else if (i_ce) begin
			if (set_p)
				o_flag_p <= 1'b1;
			else if (clr_p)
				o_flag_p <= 1'b0;
		end
	end

endmodule

// file: hw/compact_timer_defs.vh
// Register map, field positions and reset values of the compact timer
`ifndef COMPACT_TIMER_DEFS_VH
`define COMPACT_TIMER_DEFS_VH

// Byte addresses, one aligned word per register
`define CT_ADDR_CTRL0      8'h00
`define CT_ADDR_CTRL1      8'h04
`define CT_ADDR_CNT_LO     8'h08
`define CT_ADDR_CNT_HI     8'h0c
`define CT_ADDR_CMPA_LO    8'h10
`define CT_ADDR_CMPA_HI    8'h14
`define CT_ADDR_PERIOD     8'h18
`define CT_ADDR_FLAGS      8'h1c

// Control register 0 fields
`define CT_C0_ENABLE       3

// Control register 1 fields
`define CT_C1_MODE_HI      7
`define CT_C1_MODE_LO      6
`define CT_C1_PIN_HI       5
`define CT_C1_PIN_LO       4
`define CT_C1_OUT_CTRL     3
`define CT_C1_POLARITY     2
`define CT_C1_SWAP         1
`define CT_C1_CLR_SEL      0

// Flag register fields, write one to clear
`define CT_FLAG_A          0
`define CT_FLAG_P          1

// Modes
`define CT_MODE_CMP        2'b00
`define CT_MODE_PWM        2'b10
`define CT_MODE_TMR        2'b11

// Pin function codes
`define CT_PIN_NONE        2'b00
`define CT_PIN_LOW         2'b01
`define CT_PIN_HIGH        2'b10
`define CT_PIN_TOGGLE      2'b11

// Reset values
`define CT_RST_BYTE        8'h00
`define CT_RST_COUNT       16'h0000

// AHB codes
`define CT_HTRANS_NONSEQ   2'b10
`define CT_HSIZE_WORD      3'b010

`endif
